// file: logic/bdz_pkg.sv
// Package for the six-zone bus differential block: register map, fields, settings records
`default_nettype none
package bdz_pkg;
  localparam int NZ = 6;
  localparam int NPH = 3;
  localparam int NSRC = 4;
  localparam int CW = 16;
  localparam int PW = 2 * CW + 2;
  // Register map, byte addresses
  localparam logic [7:0] A_GEN = 8'h00;  // Per zone: stride 4
  localparam logic [7:0] A_THR_BASE = 8'h20;
  localparam logic [7:0] A_GRPCTL = 8'h80;
  localparam logic [7:0] A_STAT = 8'h84;
  localparam logic [7:0] A_EVT = 8'h88;
  localparam logic [7:0] A_DIFF_BASE = 8'h90;
  // Threshold record index within a zone/group: pickup, slopes, breakpoints, unbiased
  localparam int NTHR = 6;
  localparam logic [2:0] T_PKP = 3'h0;
  localparam logic [2:0] T_SL1 = 3'h1;
  localparam logic [2:0] T_BP1 = 3'h2;
  localparam logic [2:0] T_BP2 = 3'h3;
  localparam logic [2:0] T_SL2 = 3'h4;
  localparam logic [2:0] T_UNB = 3'h5;
  // General register bits
  localparam int GB_EN = 0;
  localparam int GB_CHK = 1;
  localparam int GB_EVT = 2;
  localparam int GB_BLK = 3;
  localparam int SLOPE_SH = 7;  // Slope in 1/128 units
  localparam logic [CW-1:0] D_PKP = 16'h0019;
  localparam logic [CW-1:0] D_SL1 = 16'h0020;
  localparam logic [CW-1:0] D_BP1 = 16'h0200;
  localparam logic [CW-1:0] D_BP2 = 16'h0800;
  localparam logic [CW-1:0] D_SL2 = 16'h004d;
  localparam logic [CW-1:0] D_UNB = 16'h0800;
  localparam logic [3:0] D_GEN = 4'h4;

  typedef struct packed {
    logic signed [CW:0] re;
    logic signed [CW:0] im;
  } bdz_phasor_t;

  typedef struct packed {
    logic [NPH-1:0] op_biased;
    logic [NPH-1:0] op_unbiased;
    logic [NPH-1:0] direction;
    logic [NPH-1:0] saturation;
    logic op;
    logic trip_bus;
  } bdz_zone_out_t;
endpackage : bdz_pkg
`default_nettype wire

// file: logic/bdz_top.sv
// Six-zone bus differential comparators, integration logic and Avalon-MM settings slave
`default_nettype none
module bdz_top
  import bdz_pkg::*;
#(
  parameter bit GROUP_DYNAMIC = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire bdz_phasor_t [NSRC-1:0][NPH-1:0] src_current,
  input wire logic [NZ-1:0][NSRC-1:0] src_connected,
  input wire logic group_sel,
  input wire logic [NZ-1:0] zone_block,
  input wire logic [NZ-1:0] aux_zone_trip,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NZ-1:0] zone_differential_operate,
  output logic [NZ-1:0] zone_trip_bus,
  output logic [NZ-1:0] zone_check_operate,
  output logic [NZ-1:0][NPH-1:0][CW-1:0] zone_diff_mag,
  output logic [NZ-1:0][NPH-1:0][CW-1:0] zone_rest_mag,
  output logic event_valid,
  output logic [7:0] event_code
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NZ-1:0][3:0] gen;
    logic [1:0][NZ-1:0][NTHR-1:0][CW-1:0] thr;
    logic grp_fixed;
    logic grp_mode_dyn;
    logic ack;
    logic [31:0] rdata;
    logic [NZ-1:0] op;
    logic [NZ-1:0] trip;
    logic [NZ-1:0] chk;
    logic [NZ-1:0][NPH-1:0][CW-1:0] dmag;
    logic [NZ-1:0][NPH-1:0][CW-1:0] rmag;
    logic [NZ-1:0] prev_op;
    logic [NZ-1:0] evt_pend;
    logic evt_v;
    logic [7:0] evt_c;
    logic [31:0] evt_cnt;
  } bdz_state_t;

  bdz_state_t s_r, s_nxt;

  function automatic logic [CW-1:0] mag_est(input logic signed [CW+1:0] re, input logic signed [CW+1:0] im);
    logic [CW+1:0] ar, ai, mx, mn, m;
    ar = re[CW+1] ? (CW+2)'(-re) : re;
    ai = im[CW+1] ? (CW+2)'(-im) : im;
    mx = (ar > ai) ? ar : ai;
    mn = (ar > ai) ? ai : ar;
    // Max plus three eighths of min
    m = mx + (mn >> 2) + (mn >> 3);
    mag_est = (m[CW+1:CW] != 2'b00) ? {CW{1'b1}} : m[CW-1:0];
  endfunction : mag_est

  // ****************************************
  // Comparators
  // ****************************************
  logic active_grp;
  bdz_zone_out_t [NZ-1:0] zo;
  logic [NZ-1:0][NPH-1:0][CW-1:0] dcalc, rcalc;

  always_comb begin
    active_grp = s_r.grp_mode_dyn ? group_sel : s_r.grp_fixed;
  end

  always_comb begin
    logic signed [CW+3:0] sre;
    logic signed [CW+3:0] sim;
    logic signed [CW+3:0] rre;
    logic signed [CW+3:0] rim;
    logic [CW-1:0] m;
    logic [CW-1:0] mmax;
    logic [CW-1:0] pkp;
    logic [CW-1:0] sl1;
    logic [CW-1:0] bp1;
    logic [CW-1:0] bp2;
    logic [CW-1:0] sl2;
    logic [CW-1:0] unb;
    logic [2*CW:0] lim;
    logic [$clog2(NSRC)-1:0] fidx;
    logic signed [2*CW+5:0] dot;
    logic biased;
    logic dirok;
    logic sat;
    logic hi_reg;
    sre = '0;
    sim = '0;
    rre = '0;
    rim = '0;
    m = '0;
    mmax = '0;
    lim = '0;
    fidx = '0;
    dot = '0;
    biased = 1'b0;
    dirok = 1'b0;
    sat = 1'b0;
    hi_reg = 1'b0;
    pkp = '0;
    sl1 = '0;
    bp1 = '0;
    bp2 = '0;
    sl2 = '0;
    unb = '0;
    for (int z = 0; z < NZ; z++) begin
      pkp = s_r.thr[active_grp][z][T_PKP];
      sl1 = s_r.thr[active_grp][z][T_SL1];
      bp1 = s_r.thr[active_grp][z][T_BP1];
      bp2 = s_r.thr[active_grp][z][T_BP2];
      sl2 = s_r.thr[active_grp][z][T_SL2];
      unb = s_r.thr[active_grp][z][T_UNB];
      for (int p = 0; p < NPH; p++) begin
        sre = '0;
        sim = '0;
        mmax = '0;
        fidx = '0;
        // ****************************************
        // Source sums over the connected sources
        // ****************************************
        // Raw phasors are used, no cutoff is applied here
        for (int k = 0; k < NSRC; k++) begin
          if (src_connected[z][k]) begin
            sre = sre + (CW+4)'(src_current[k][p].re);
            sim = sim + (CW+4)'(src_current[k][p].im);
            m = mag_est((CW+2)'(src_current[k][p].re), (CW+2)'(src_current[k][p].im));
            if (m > mmax) begin
              mmax = m;
              fidx = ($clog2(NSRC))'(k);
            end
          end
        end
        dcalc[z][p] = mag_est(sre[CW+1:0], sim[CW+1:0]);
        if (sre[CW+3:CW+1] != {3{sre[CW+1]}} || sim[CW+3:CW+1] != {3{sim[CW+1]}}) begin
          dcalc[z][p] = {CW{1'b1}};
        end
        rcalc[z][p] = mmax;
        // ****************************************
        // Restraint characteristic
        // ****************************************
        // Dual-slope limit
        if (mmax <= bp1) begin
          lim = ((2*CW+1)'(mmax) * (2*CW+1)'(sl1)) >> SLOPE_SH;
        end else if (mmax >= bp2) begin
          lim = ((2*CW+1)'(mmax) * (2*CW+1)'(sl2)) >> SLOPE_SH;
        end else begin
          lim = ((2*CW+1)'(bp1) * (2*CW+1)'(sl1) + (2*CW+1)'(mmax - bp1) * (2*CW+1)'(sl2)) >> SLOPE_SH;
        end
        biased = (dcalc[z][p] > pkp) && ((2*CW+1)'(dcalc[z][p]) > lim);
        // ****************************************
        // Direction and saturation supervision
        // ****************************************
        // Faulted source against the rest of the zone
        rre = sre - (CW+4)'(src_current[fidx][p].re);
        rim = sim - (CW+4)'(src_current[fidx][p].im);
        dot = (2*CW+6)'(rre) * (2*CW+6)'(src_current[fidx][p].re)
            + (2*CW+6)'(rim) * (2*CW+6)'(src_current[fidx][p].im);
        dirok = (dot > 0) || (rre == 0 && rim == 0);
        hi_reg = (mmax > bp1);
        // Saturation: restraint above breakpoint yet differential small
        sat = hi_reg && ((2*CW+1)'(dcalc[z][p]) <= lim + (2*CW+1)'(pkp));
        if (!hi_reg) begin
          zo[z].op_biased[p] = biased && dirok;
        end else if (sat) begin
          zo[z].op_biased[p] = biased && dirok;
        end else begin
          zo[z].op_biased[p] = biased;
        end
        zo[z].op_unbiased[p] = dcalc[z][p] > unb;
        zo[z].direction[p] = dirok;
        zo[z].saturation[p] = sat;
      end
      zo[z].op = |(zo[z].op_biased | zo[z].op_unbiased);
      zo[z].trip_bus = 1'b0;
    end
  end

  // ****************************************
  // Integration, events and bus slave
  // ****************************************
  always_comb begin
    logic [2:0] zi;
    logic [2:0] ti;
    logic [2:0] gz;
    logic [2:0] ri;
    logic [NZ-1:0] blk;
    logic [NZ-1:0] zone_go;
    logic grp_ix;
    logic take;
    logic wr_go;
    logic in_gen;
    logic in_thr;
    logic in_ctl;
    logic in_stat;
    logic in_evt;
    logic [31:0] rv;
    zi = '0;
    ti = '0;
    gz = '0;
    ri = '0;
    blk = '0;
    zone_go = '0;
    grp_ix = 1'b0;
    take = 1'b0;
    wr_go = 1'b0;
    in_gen = 1'b0;
    in_thr = 1'b0;
    in_ctl = 1'b0;
    in_stat = 1'b0;
    in_evt = 1'b0;
    rv = '0;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.evt_v = 1'b0;
    // ****************************************
    // Zone integration
    // ****************************************
    for (int z = 0; z < NZ; z++) begin
      // Block comes from the pin or the general register
      blk[z] = zone_block[z] | s_r.gen[z][GB_BLK];
      zone_go[z] = s_r.gen[z][GB_EN] && zo[z].op && !blk[z];
    end
    if (sample_valid) begin
      for (int z = 0; z < NZ; z++) begin
        if (!s_r.gen[z][GB_EN]) begin
          s_nxt.op[z] = 1'b0;
          s_nxt.chk[z] = 1'b0;
          s_nxt.dmag[z] = '0;
          s_nxt.rmag[z] = '0;
        end else begin
          s_nxt.op[z] = zone_go[z];
          s_nxt.chk[z] = zone_go[z] && s_r.gen[z][GB_CHK];
          s_nxt.dmag[z] = dcalc[z];
          s_nxt.rmag[z] = rcalc[z];
        end
        // Check zone supervises only, never drives trip bus
        if (s_r.gen[z][GB_CHK]) begin
          s_nxt.trip[z] = 1'b0;
        end else begin
          // Auxiliary trip acts even on a disabled zone
          s_nxt.trip[z] = aux_zone_trip[z] || zone_go[z];
        end
      end
    end
    // ****************************************
    // Event recorder
    // ****************************************
    // Lowest pending zone is served first
    for (int z = NZ - 1; z >= 0; z--) begin
      if (s_r.evt_pend[z]) begin
        ri = 3'(z);
      end
    end
    if (|s_r.evt_pend) begin
      s_nxt.evt_pend[ri] = 1'b0;
      s_nxt.evt_v = 1'b1;
      s_nxt.evt_c = {4'h0, s_r.op[ri], ri};
      s_nxt.evt_cnt = s_r.evt_cnt + 32'h1;
    end
    // New changes are latched after the service clear so that none is lost
    for (int z = 0; z < NZ; z++) begin
      s_nxt.prev_op[z] = s_r.op[z];
      if (s_r.op[z] != s_r.prev_op[z] && s_r.gen[z][GB_EVT]) begin
        s_nxt.evt_pend[z] = 1'b1;
      end
    end
    // ****************************************
    // Bus decode
    // ****************************************
    // Read data is captured on the taking edge and stands through the answer
    take = (avs_read || avs_write) && !s_r.ack;
    // Writes land on the edge at which waitrequest is low
    wr_go = avs_write && s_r.ack;
    if (take) begin
      s_nxt.ack = 1'b1;
    end
    if (avs_address < A_THR_BASE) begin
      in_gen = 1'b1;
    end else if (avs_address < A_GRPCTL) begin
      in_thr = 1'b1;
    end else if (avs_address == A_GRPCTL) begin
      in_ctl = 1'b1;
    end else if (avs_address == A_STAT) begin
      in_stat = 1'b1;
    end else if (avs_address == A_EVT) begin
      in_evt = 1'b1;
    end
    // ****************************************
    // Register access
    // ****************************************
    if (in_gen) begin
      gz = avs_address[4:2];
      if (gz < 3'(NZ)) begin
        rv = {28'h0, s_r.gen[gz]};
        if (wr_go && avs_byteenable[0]) begin
          s_nxt.gen[gz] = avs_writedata[3:0];
        end
      end
    end
    if (in_thr) begin
      // Threshold block: zone(3) item(3); group is address bit 7, so only group 0 and zones 0 to 2 are reached
      zi = 3'((avs_address - A_THR_BASE) >> 5);
      ti = avs_address[4:2];
      grp_ix = avs_address[7];
      if (zi < 3'(NZ) && ti < 3'(NTHR)) begin
        rv = {16'h0, s_r.thr[grp_ix][zi][ti]};
        if (wr_go && avs_byteenable[1:0] == 2'b11) begin
          s_nxt.thr[grp_ix][zi][ti] = avs_writedata[CW-1:0];
        end
      end
    end
    if (in_ctl) begin
      rv = {29'h0, active_grp, s_r.grp_mode_dyn, s_r.grp_fixed};
      if (wr_go && avs_byteenable[0]) begin
        s_nxt.grp_fixed = avs_writedata[0];
        s_nxt.grp_mode_dyn = avs_writedata[1] & GROUP_DYNAMIC;
      end
    end
    if (in_stat) begin
      rv = {8'h0, 2'h0, s_r.chk, 2'h0, s_r.trip, 2'h0, s_r.op};
    end
    if (in_evt) begin
      rv = s_r.evt_cnt;
    end
    // Unmapped reads return zero
    if (take) begin
      s_nxt.rdata = rv;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Settings return to their defaults on reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
      for (int z = 0; z < NZ; z++) begin
        s_r.gen[z] <= D_GEN;
        for (int g = 0; g < 2; g++) begin
          s_r.thr[g][z] <= {D_UNB, D_SL2, D_BP2, D_BP1, D_SL1, D_PKP};
        end
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Only waitrequest is combinational, the rest come from the state register
  always_comb begin
    avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
    avs_readdata = s_r.rdata;
    zone_differential_operate = s_r.op;
    zone_trip_bus = s_r.trip;
    zone_check_operate = s_r.chk;
    zone_diff_mag = s_r.dmag;
    zone_rest_mag = s_r.rmag;
    event_valid = s_r.evt_v;
    event_code = s_r.evt_c;
  end
endmodule : bdz_top
`default_nettype wire

// file: dv/bdz_chk_assertions.sv
// Concurrent checks on the ports of the bus differential block
`default_nettype none
module bdz_chk
  import bdz_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic [NZ-1:0] zone_block,
  input wire logic [NZ-1:0] aux_zone_trip,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NZ-1:0] zone_differential_operate,
  input wire logic [NZ-1:0] zone_trip_bus,
  input wire logic [NZ-1:0][NPH-1:0][CW-1:0] zone_diff_mag,
  input wire logic event_valid,
  input wire logic [7:0] event_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence req_s; $rose(avs_read || avs_write); endsequence
  sequence ack_s; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence rd_done_s; avs_read && !avs_waitrequest ##1 !(avs_read || avs_write); endsequence
  bus_wait_a: assert property (req_s |-> ack_s) else $error("bus answer not after one wait");
  rd_stand_a: assert property (rd_done_s |-> $stable(avs_readdata)) else $error("read data moved");
  blk_op_a: assert property (sample_valid |=> (zone_differential_operate & $past(zone_block)) == '0)
    else $error("blocked zone operated");
  blk_trip_a: assert property (sample_valid && zone_block[0] && !aux_zone_trip[0] |=> !zone_trip_bus[0])
    else $error("blocked zone tripped");
  op_mag_a: assert property (zone_differential_operate[0] |-> zone_diff_mag[0] != '0)
    else $error("operate without differential");
  op_mag_last_a: assert property (zone_differential_operate[5] |-> zone_diff_mag[5] != '0)
    else $error("last zone operate without differential");
  rst_clear_a: assert property ($fell(rst) |-> zone_differential_operate == '0 && zone_trip_bus == '0)
    else $error("outputs not clear after reset");
  evt_code_a: assert property (event_valid |-> event_code[7:4] == 4'h0 && event_code[2:0] < 3'h6)
    else $error("bad event code");
  evt_follow_a: assert property ($changed(zone_differential_operate[0]) |-> ##[1:12] event_valid)
    else $error("no event after operate change");
endmodule : bdz_chk
bind bdz_top bdz_chk i_chk (.core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
  .zone_block(zone_block), .aux_zone_trip(aux_zone_trip), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .zone_differential_operate(zone_differential_operate), .zone_trip_bus(zone_trip_bus),
  .zone_diff_mag(zone_diff_mag), .event_valid(event_valid), .event_code(event_code));
`default_nettype wire

// file: dv/bdz_src_model.sv
// Bus source element model: sampled currents and dynamic replica status
`default_nettype none
module bdz_src_model
  import bdz_pkg::*;
(
  input wire logic core_clk,
  input wire logic signed [CW:0] amp_a,
  input wire logic signed [CW:0] amp_b,
  input wire logic [NSRC-1:0] conn,
  output var bdz_phasor_t [NSRC-1:0][NPH-1:0] src_current,
  output var logic [NZ-1:0][NSRC-1:0] src_connected
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Source replica
  // ****
  bdz_phasor_t [NSRC-1:0][NPH-1:0] cur;
  always_comb begin
    cur = '0;
    cur[0][0].re = amp_a;
    cur[1][0].re = amp_b;
  end
  always @(posedge core_clk) begin
    src_current <= cur;
    src_connected <= {NZ{conn}};
  end
endmodule : bdz_src_model
`default_nettype wire

// file: dv/tb_bus_differential_zone_logic.sv
// Self-checking bench of the six-zone bus differential block
`default_nettype none
module tb_bus_differential_zone_logic
  import bdz_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Stimulus and checks
  // ****
  localparam int NR = 6;
  logic core_clk = 0, rst = 1, sample_valid = 1, group_sel = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [NZ-1:0] zone_block = '0, aux_zone_trip = '0, op, trip, chk_op;
  logic [7:0] avs_address = '0, event_code, ev_last;
  logic [31:0] avs_writedata = '0, rd, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic signed [CW:0] amp_a = '0, amp_b = '0;
  logic [NSRC-1:0] conn = '0;
  bdz_phasor_t [NSRC-1:0][NPH-1:0] src_current;
  logic [NZ-1:0][NSRC-1:0] src_connected;
  logic [NZ-1:0][NPH-1:0][CW-1:0] dmag, rmag;
  logic event_valid;
  int fails = 0, n_tests = 0, cyc = 0, ev_n = 0, e0 = 0;
  logic [CW:0] ra[NR] = '{17'h00080, 17'h00300, 17'h1fd00, 17'h00500, 17'h00002, 17'h00300};
  logic [CW:0] rb[NR] = '{17'h00080, 17'h00300, 17'h00300, 17'h00500, 17'h00002, 17'h00500};
  logic [3:0] rc[NR] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h1};
  logic [1:0] ro[NR] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1};
  logic [15:0] rdf[NR] = '{16'h0100, 16'h0600, 16'h0000, 16'h0a00, 16'h0004, 16'h0300};
  logic [15:0] rr[NR] = '{16'h0080, 16'h0300, 16'h0300, 16'h0500, 16'h0002, 16'h0300};

  bdz_top #(.GROUP_DYNAMIC(1'b1)) i_dut (.core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
    .src_current(src_current), .src_connected(src_connected), .group_sel(group_sel), .zone_block(zone_block),
    .aux_zone_trip(aux_zone_trip), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .zone_differential_operate(op), .zone_trip_bus(trip),
    .zone_check_operate(chk_op), .zone_diff_mag(dmag), .zone_rest_mag(rmag), .event_valid(event_valid),
    .event_code(event_code));
  bdz_src_model i_src (.core_clk(core_clk), .amp_a(amp_a), .amp_b(amp_b), .conn(conn),
    .src_current(src_current), .src_connected(src_connected));

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task apply(input int i);
    @(posedge core_clk);
    amp_a <= ra[i];
    amp_b <= rb[i];
    conn <= rc[i];
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
  endtask : apply

  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (event_valid === 1'b1) begin
    ev_n++;
    ev_last = event_code;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    apply(1);
    chk(32'(op), 32'h0, "op_disabled");
    chk(32'(dmag[0][0]), 32'h0, "diff_disabled");
    bus(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h4, "gen_reset");
    bus(8'hfc, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped");
    for (int z = 0; z < NZ; z++) bus(8'(4 * z), 1'b1, 32'h5);
    bus(8'h14, 1'b0, 32'h0);
    chk(rd, 32'h5, "gen_write");
    for (int i = 0; i < NR; i++) begin
      apply(i);
      for (int z = 0; z < NZ; z++) begin
        if (ro[i] != 2'h2) chk(32'(op[z]), 32'(ro[i][0]), "op");
        chk(32'(dmag[z][0]), 32'(rdf[i]), "diff");
        chk(32'(rmag[z][0]), 32'(rr[i]), "rest");
      end
    end
    apply(1);
    @(posedge core_clk);
    zone_block <= 6'h01;
    apply(1);
    chk(32'(op), 32'h3e, "op_blocked");
    chk(32'(trip[0]), 32'h0, "trip_blocked");
    e0 = ev_n;
    @(posedge core_clk);
    zone_block <= 6'h00;
    apply(1);
    chk(32'(ev_n - e0), 32'h1, "event_count");
    chk(32'(ev_last), 32'h08, "event_code");
    bus(8'h04, 1'b1, 32'h7);
    @(posedge core_clk);
    aux_zone_trip <= 6'h0a;
    apply(4);
    chk(32'(trip), 32'h08, "trip_aux");
    apply(1);
    chk(32'(trip), 32'h3d, "trip_check_zone");
    chk(32'(chk_op), 32'h02, "check_op");
    bus(A_STAT, 1'b0, 32'h0);
    chk(rd, 32'h00023d3f, "status");
    bus(A_EVT, 1'b0, 32'h0);
    chk(rd, 32'(ev_n), "event_total");
    bus(A_GRPCTL, 1'b1, 32'h2);
    group_sel <= 1'b1;
    bus(A_GRPCTL, 1'b0, 32'h0);
    chk(rd, 32'h6, "group_dynamic");
    give_verdict();
  end
endmodule : tb_bus_differential_zone_logic
`default_nettype wire
